// [hdl/hbdl_core.sv]
// gate control with active demagnetization and cycle-by-cycle current limit
// Operation
// - turn FET on when its diode conducts
// - high and low reverse comparators per bridge
// - protect/rectify pin decodes four modes
// - commutation: FET on while diode conducts
// - PWM off-time: low FET on on diode
// - async mode: low FET off near zero
// - limit trips on low-side current over threshold
// - high FET held off until next cycle
// - recirculation bit picks brake or high-impedance
// - limit comparator blanked after PWM rises
// - threshold at half supply disables limiting
// - five configuration pins read as four-level
// - gain from pin or register field
// - internal 20/40 kHz clock re-enables high FET
//
// The register offsets and the strobed register port were left to the implementer.
module hbdl_core
  import hbdl_pkg::*;
#(
  parameter int NPH         = 3,
  parameter int BLANK_CYC_P = BLANK_CYC
) (
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire hbdl_phase_in_t [NPH-1:0]   phase_in,
  input  wire logic                       limit_comparator,
  input  wire logic                       limit_threshold_at_half,
  input  wire hbdl_strap_t                strap_in,
  input  wire logic                       pin_configured,
  input  wire logic [ADDR_W-1:0]          addr,
  input  wire logic [DATA_W-1:0]          wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [DATA_W-1:0]          rdata,
  output wire hbdl_gate_t [NPH-1:0]       gate_out,
  output logic      [1:0]                 sense_amp_gain,
  output logic                            ocp_level_24a,
  output logic      [1:0]                 slew_sel,
  output logic      [1:0]                 mode_sel,
  output logic      [1:0]                 buck_sel
);

  localparam int PH_W    = $bits(hbdl_phase_in_t) * NPH;
  localparam int ST_W    = $bits(hbdl_strap_t);
  localparam int ASYNC_W = PH_W + ST_W + 3;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================================
  // input synchroniser: a bit moves once stages two and three agree
  logic [ASYNC_W-1:0] raw;
  logic [ASYNC_W-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [ASYNC_W-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;

  assign raw = {limit_comparator, limit_threshold_at_half, pin_configured, strap_in, phase_in};

  always_comb begin
    s1_nxt = raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    for (int i = 0; i < ASYNC_W; i++) begin
      filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      filt_r <= filt_nxt;
    end
  end

  hbdl_phase_in_t [NPH-1:0] ph_s;
  hbdl_strap_t              strap_s;
  logic                     pincfg_s;
  logic                     lim_half_s;
  logic                     lim_cmp_s;

  assign ph_s       = filt_r[PH_W-1:0];
  assign strap_s    = filt_r[PH_W +: ST_W];
  assign pincfg_s   = filt_r[PH_W + ST_W];
  assign lim_half_s = filt_r[PH_W + ST_W + 1];
  assign lim_cmp_s  = filt_r[PH_W + ST_W + 2];

  // ==========================================================================
  // strap capture: pins are read once, after the synchroniser has filled
  hbdl_state_t         st_r, st_nxt;
  logic [SETTLE_W-1:0] settle_r, settle_nxt;
  hbdl_strap_t         strap_r, strap_nxt;
  logic                pincfg_r, pincfg_nxt;

  always_comb begin
    st_nxt     = st_r;
    settle_nxt = settle_r;
    strap_nxt  = strap_r;
    pincfg_nxt = pincfg_r;
    unique case (st_r)
      ST_SETTLE: begin
        settle_nxt = settle_r + SETTLE_W'(1);
        if (settle_r == SETTLE_W'(SETTLE_CYC)) begin
          st_nxt     = ST_RUN;
          strap_nxt  = strap_s;
          pincfg_nxt = pincfg_s;
        end
      end
      ST_RUN: begin
        st_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r     <= ST_SETTLE;
      settle_r <= '0;
      strap_r  <= '0;
      pincfg_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      settle_r <= settle_nxt;
      strap_r  <= strap_nxt;
      pincfg_r <= pincfg_nxt;
    end
  end

  // ==========================================================================
  // register port and effective configuration
  hbdl_ctrl_t         ctrl_r, ctrl_nxt;
  logic [DATA_W-1:0]  rdata_nxt;
  logic [1:0]         gain_nxt, slew_nxt, mode_nxt, buck_nxt;
  logic               ocp_nxt;
  logic               running;
  logic               demag_en;
  logic               recirc_brake;
  logic [NPH-1:0]     hold_v;
  logic [NPH-1:0]     high_v;
  logic [NPH-1:0]     low_v;

  assign running      = (st_r == ST_RUN);
  // the serial variant only rectifies with both enable bits set
  assign demag_en     = pincfg_r ? strap_r.prot_rect[LVL_RECT_BIT]
                                 : (ctrl_r.sync_rectify_enable
                                    & ctrl_r.async_rectify_enable);
  assign recirc_brake = ctrl_r.limit_recirculation_select;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr && hit(addr, OFF_CTRL)) begin
      ctrl_nxt = wdata[CTRL_W-1:0];
    end
    rdata_nxt = '0;
    if (rd && hit(addr, OFF_CTRL)) begin
      rdata_nxt[CTRL_W-1:0] = ctrl_r;
    end else if (rd && hit(addr, OFF_STATUS)) begin
      rdata_nxt[3*NPH+3:0] = {sense_amp_gain, demag_en, running, hold_v, low_v, high_v};
    end else if (rd && hit(addr, OFF_STRAP)) begin
      rdata_nxt[ST_W:0] = {pincfg_r, strap_r};
    end
    gain_nxt = pincfg_r ? strap_r.gain : ctrl_r.sense_amp_gain;
    ocp_nxt  = strap_r.prot_rect[LVL_OCP_BIT];
    slew_nxt = strap_r.slew;
    mode_nxt = strap_r.mode;
    buck_nxt = strap_r.buck;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r         <= CTRL_RESET;
      rdata          <= '0;
      sense_amp_gain <= '0;
      ocp_level_24a  <= 1'b0;
      slew_sel       <= '0;
      mode_sel       <= '0;
      buck_sel       <= '0;
    end else begin
      ctrl_r         <= ctrl_nxt;
      rdata          <= rdata_nxt;
      sense_amp_gain <= gain_nxt;
      ocp_level_24a  <= ocp_nxt;
      slew_sel       <= slew_nxt;
      mode_sel       <= mode_nxt;
      buck_sel       <= buck_nxt;
    end
  end

  chk_gain_pin: assert property (running && pincfg_r |=> sense_amp_gain == $past(strap_r.gain))
    else $error("gain does not follow pin in pin variant");

  // ==========================================================================
  // internal periodic clock for full-duty inputs (hardware variant fixed slow)
  logic [TICK_W-1:0] tick_r, tick_nxt;
  logic              tick;
  logic [TICK_W-1:0] period_m1;

  assign period_m1 = (ctrl_r.pwm100_fast && !pincfg_r) ? TICK_W'(PWM100_FAST_CYC - 1)
                                                       : TICK_W'(PWM100_SLOW_CYC - 1);
  assign tick      = (tick_r >= period_m1);

  always_comb begin
    tick_nxt = tick ? '0 : tick_r + TICK_W'(1);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  chk_tick_spacing: assert property (tick |=> !tick [*8])
    else $error("internal cycle ticks too close");

  // ==========================================================================
  // per-phase gate logic
  for (genvar p = 0; p < NPH; p++) begin : g_ph
    hbdl_phase_in_t     ph;
    logic               hi_d_r, hi_d_nxt;
    logic               rl_d_r, rl_d_nxt;
    logic [BLANK_W-1:0] blank_r, blank_nxt;
    logic               hold_r, hold_nxt;
    logic               aar_r, aar_nxt;
    hbdl_gate_t         gate_r, gate_nxt;
    logic               hs_rise, trip, asr_ls, asr_hs;

    assign ph      = ph_s[p];
    assign hs_rise = ph.pwm_high && !hi_d_r;
    // a tripped limit is ignored until the blanking count runs out
    assign trip    = running && !lim_half_s && lim_cmp_s && ph.pwm_high
                     && blank_r == '0 && !hs_rise;
    // both FETs commanded off and a reverse comparator trips: diode conducts
    assign asr_ls  = demag_en && !ph.pwm_high && !ph.pwm_low && ph.rev_low;
    assign asr_hs  = demag_en && !ph.pwm_high && !ph.pwm_low && ph.rev_high;

    always_comb begin
      hi_d_nxt  = ph.pwm_high;
      rl_d_nxt  = ph.rev_low;
      blank_nxt = hs_rise ? BLANK_W'(BLANK_CYC_P)
                          : (blank_r != '0 ? blank_r - BLANK_W'(1) : blank_r);
      // trip wins over a same-cycle release
      hold_nxt  = trip ? 1'b1 : ((hs_rise || tick) ? 1'b0 : hold_r);
      // falling low comparator while low FET on means current near zero
      aar_nxt   = ph.pwm_low && ((demag_en && rl_d_r && !ph.rev_low) || aar_r);
      gate_nxt.high = running && !hold_nxt && (ph.pwm_high || asr_hs);
      gate_nxt.low  = running && !gate_nxt.high
                      && (hold_nxt ? recirc_brake
                                   : ((ph.pwm_low && !aar_nxt) || asr_ls));
    end

    always_ff @(posedge clock) begin
      if (reset) begin
        hi_d_r  <= 1'b0;
        rl_d_r  <= 1'b0;
        blank_r <= '0;
        hold_r  <= 1'b0;
        aar_r   <= 1'b0;
        gate_r  <= '0;
      end else begin
        hi_d_r  <= hi_d_nxt;
        rl_d_r  <= rl_d_nxt;
        blank_r <= blank_nxt;
        hold_r  <= hold_nxt;
        aar_r   <= aar_nxt;
        gate_r  <= gate_nxt;
      end
    end

    assign gate_out[p] = gate_r;
    assign hold_v[p]   = hold_r;
    assign high_v[p]   = gate_r.high;
    assign low_v[p]    = gate_r.low;

    sequence s_pwm_rise;
      hs_rise;
    endsequence

    sequence s_limit_trip;
      running && !lim_half_s && lim_cmp_s && ph.pwm_high && blank_r == '0 && !hs_rise;
    endsequence

    chk_hs_held_off: assert property (hold_r |-> !gate_r.high)
      else $error("high FET on while limit hold active");
    chk_blank_window: assert property (s_pwm_rise |=> !hold_r [*8])
      else $error("limit tripped inside blanking window");
    chk_trip_sets: assert property (s_limit_trip |=> hold_r && !gate_r.high)
      else $error("limit trip did not disable high FET");
    chk_recirc_brake: assert property (hold_r && $past(recirc_brake) |-> gate_r.low)
      else $error("brake recirculation lost low FET");
    chk_recirc_hiz: assert property (hold_r && !$past(recirc_brake) |-> !gate_r.low)
      else $error("high-impedance recirculation drove low FET");
    chk_asr_low: assert property (running && asr_ls && !hold_nxt |=> gate_r.low)
      else $error("low diode conduction not rectified");
    chk_asr_high: assert property (running && asr_hs && !hold_nxt |=> gate_r.high)
      else $error("high diode conduction not rectified");
    chk_aar_cut: assert property (aar_r && !hold_r |-> !gate_r.low)
      else $error("low FET left on after current reached zero");
    chk_no_shoot: assert property (!(gate_r.high && gate_r.low))
      else $error("both FETs of one bridge on");
  end

endmodule

// [hdl/hbdl_pkg.sv]
// shared constants and types for the half-bridge demag and current-limit block
package hbdl_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ         = 50;
  localparam int CLK_HZ          = CLK_MHZ * 1_000_000;
  localparam int BLANK_NS        = 200;
  localparam int BLANK_CYC       = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int PWM100_SLOW_HZ  = 20_000;
  localparam int PWM100_FAST_HZ  = 40_000;
  localparam int PWM100_SLOW_CYC = CLK_HZ / PWM100_SLOW_HZ;
  localparam int PWM100_FAST_CYC = CLK_HZ / PWM100_FAST_HZ;
  localparam int TICK_W          = 12;
  localparam int BLANK_W         = 8;
  localparam int SETTLE_CYC      = 4;
  localparam int SETTLE_W        = 3;

  // ==========================================================================
  // register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STRAP  = 4'h8;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  // four-level pin code: bit 1 selects rectify on, bit 0 the 24 A level
  localparam int LVL_RECT_BIT = 1;
  localparam int LVL_OCP_BIT  = 0;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [1:0] sense_amp_gain;
    logic       pwm100_fast;
    logic       limit_recirculation_select;
    logic       async_rectify_enable;
    logic       sync_rectify_enable;
  } hbdl_ctrl_t;

  typedef struct packed {
    logic pwm_high;
    logic pwm_low;
    logic rev_high;
    logic rev_low;
  } hbdl_phase_in_t;

  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] mode;
    logic [1:0] slew;
    logic [1:0] prot_rect;
    logic [1:0] buck;
  } hbdl_strap_t;

  typedef struct packed {
    logic high;
    logic low;
  } hbdl_gate_t;

  typedef enum logic {
    ST_SETTLE,
    ST_RUN
  } hbdl_state_t;

endpackage

// [verification/hbdl_mcu_model.sv]
// external controller model driving the per-phase pwm commands
module hbdl_mcu_model (
  input  wire logic       clock,
  output logic      [2:0] pwm_high,
  output logic      [2:0] pwm_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pwm_high = 3'h0;
    pwm_low  = 3'h0;
  end
  // a level holds until the next command, so 100% duty is just never dropping it
  task automatic drive(int ph, logic h, logic l);
    @(posedge clock);
    pwm_high[ph] <= h & ~l;
    pwm_low[ph]  <= l;
  endtask
endmodule

// [verification/test_hbdl_core.sv]
// self-checking bench for the gate-control core
module test_hbdl_core
  import hbdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  k;
    logic [31:0] e;
  } hbdl_note_t;
  logic                 clock    = 1'b0;
  logic                 reset    = 1'b1;
  logic                 wr       = 1'b0;
  logic                 rd       = 1'b0;
  logic                 look     = 1'b0;
  logic                 rd_seen  = 1'b0;
  logic                 lk_seen  = 1'b0;
  logic                 limit    = 1'b0;
  logic                 at_half  = 1'b0;
  logic                 pin_cfg  = 1'b0;
  logic [ADDR_W-1:0]    addr     = 4'h0;
  logic [DATA_W-1:0]    wdata    = 32'h0;
  logic [2:0]           rev_high = 3'h0;
  logic [2:0]           rev_low  = 3'h0;
  hbdl_strap_t          strap    = 10'h000;
  hbdl_phase_in_t [2:0] phase_in;
  wire logic [2:0]      ph;
  wire logic [2:0]      pl;
  wire logic [31:0]     rdata;
  wire hbdl_gate_t [2:0] gate_out;
  wire logic [8:0]      cfg;
  logic [31:0]          seed;
  hbdl_strap_t          s;
  hbdl_note_t           n;
  hbdl_note_t           notes[$];
  int                   p;
  int                   k;
  int                   n_fail   = 0;
  int                   checked  = 0;

  always #10 clock = ~clock;
  always_comb
    for (int i = 0; i < 3; i++)
      phase_in[i] = '{ph[i], pl[i], rev_high[i], rev_low[i]};

  hbdl_mcu_model mcu (.clock(clock), .pwm_high(ph), .pwm_low(pl));
  hbdl_core dut (
    .clock(clock), .reset(reset), .phase_in(phase_in), .limit_comparator(limit),
    .limit_threshold_at_half(at_half), .strap_in(strap), .pin_configured(pin_cfg),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_out(gate_out),
    .sense_amp_gain(cfg[8:7]), .ocp_level_24a(cfg[6]), .slew_sel(cfg[5:4]),
    .mode_sel(cfg[3:2]), .buck_sel(cfg[1:0])
  );

  // ==========================================================================
  // scoreboard
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge clock) begin
    rd_seen <= rd;
    lk_seen <= look;
  end
  // sampled mid-cycle so registered outputs have settled
  always @(negedge clock)
    if (rd_seen || lk_seen) begin
      n = notes.pop_front();
      case (n.k)
        2'h0: check("rdata", rdata, n.e);
        2'h1: check("gate_out", 32'(gate_out), n.e);
        default: check("config", 32'(cfg), n.e);
      endcase
    end

  // ==========================================================================
  // drivers
  task automatic tick(int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    notes.push_back('{2'h0, e});
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic look_at(logic [1:0] kd, logic [31:0] e);
    @(posedge clock);
    look <= 1'b1;
    notes.push_back('{kd, e});
    @(posedge clock);
    look <= 1'b0;
  endtask
  function automatic logic [31:0] gv(int ph_i, logic h, logic l);
    return 32'({h, l}) << (2 * ph_i);
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic do_reset(logic pc, hbdl_strap_t st);
    @(posedge clock);
    reset   <= 1'b1;
    pin_cfg <= pc;
    strap   <= st;
    tick(16);
    reset <= 1'b0;
    tick(10);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    tick(100000);
    n_fail++;
    give_verdict();
  end

  // ==========================================================================
  // scenarios
  initial begin
    seed = 32'h683c4c6a;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      s = hbdl_strap_t'(seed[9:0]);
      s.prot_rect = 2'(i);
      do_reset(1'b1, s);
      look_at(2'h2, 32'({s.gain, s.prot_rect[LVL_OCP_BIT], s.slew, s.mode, s.buck}));
      rd_reg(OFF_STATUS, 32'({s.gain, s.prot_rect[LVL_RECT_BIT], 1'b1, 9'h000}));
      rd_reg(OFF_STRAP, 32'({1'b1, s}));
    end
    $display("test straps done");
    do_reset(1'b0, hbdl_strap_t'(10'h000));
    rd_reg(OFF_CTRL, 32'h0);
    wr_reg(4'hc, 32'hffffffff);
    rd_reg(4'hc, 32'h0);
    rd_reg(OFF_CTRL, 32'h0);
    wr_reg(OFF_CTRL, 32'hfffffff0);
    rd_reg(OFF_CTRL, 32'h30);
    rd_reg(OFF_STATUS, 32'h1a00);
    $display("test registers done");
    p = int'(seed % 3);
    for (int c = 1; c < 4; c++) begin
      wr_reg(OFF_CTRL, 32'(c));
      rd_reg(OFF_STATUS, 32'h200 | (32'(c == 3) << 10));
      rev_low[p] <= 1'b1;
      tick(8);
      look_at(2'h1, gv(p, 1'b0, c == 3));
      rev_low[p] <= 1'b0;
      tick(8);
    end
    rev_high[p] <= 1'b1;
    tick(1);
    look_at(2'h1, 32'h0);
    tick(6);
    look_at(2'h1, gv(p, 1'b1, 1'b0));
    rev_high[p] <= 1'b0;
    tick(8);
    look_at(2'h1, 32'h0);
    mcu.drive(p, 1'b1, 1'b0);
    tick(8);
    mcu.drive(p, 1'b0, 1'b0);
    rev_low[p] <= 1'b1;
    tick(8);
    look_at(2'h1, gv(p, 1'b0, 1'b1));
    rev_low[p] <= 1'b0;
    mcu.drive(p, 1'b0, 1'b1);
    tick(8);
    rev_low[p] <= 1'b1;
    tick(4);
    rev_low[p] <= 1'b0;
    tick(8);
    look_at(2'h1, 32'h0);
    mcu.drive(p, 1'b0, 1'b0);
    tick(4);
    mcu.drive(p, 1'b0, 1'b1);
    tick(8);
    look_at(2'h1, gv(p, 1'b0, 1'b1));
    mcu.drive(p, 1'b0, 1'b0);
    tick(8);
    $display("test demag done");
    for (int b = 0; b < 2; b++) begin
      wr_reg(OFF_CTRL, 32'(b * 12));
      mcu.drive(p, 1'b1, 1'b0);
      tick(3);
      limit <= 1'b1;
      tick(5);
      limit <= 1'b0;
      tick(8);
      look_at(2'h1, gv(p, 1'b1, 1'b0));
      at_half <= 1'b1;
      tick(8);
      limit <= 1'b1;
      tick(8);
      look_at(2'h1, gv(p, 1'b1, 1'b0));
      limit   <= 1'b0;
      at_half <= 1'b0;
      tick(8);
      limit <= 1'b1;
      tick(8);
      look_at(2'h1, gv(p, 1'b0, b[0]));
      limit <= 1'b0;
      tick(8);
      look_at(2'h1, gv(p, 1'b0, b[0]));
      mcu.drive(p, 1'b0, 1'b0);
      tick(4);
      mcu.drive(p, 1'b1, 1'b0);
      tick(8);
      look_at(2'h1, gv(p, 1'b1, 1'b0));
      tick(12);
      limit <= 1'b1;
      tick(8);
      limit <= 1'b0;
      k = 0;
      @(negedge clock);
      while (gate_out[p].high !== 1'b1 && k < (b == 1 ? 1260 : 2510)) begin
        @(negedge clock);
        k++;
      end
      check("re_enable", 32'(gate_out[p].high), 32'h1);
      mcu.drive(p, 1'b0, 1'b0);
      tick(8);
    end
    $display("test current limit done");
    give_verdict();
  end
endmodule
